// ===== hdl/ir_carrier_generator.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module ir_carrier_generator
   import ir_carrier_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_carrier_out_pin,
   output logic o_carrier_match_irq,
   output logic o_pacer_irq
);
   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   logic carrier_timer_enable_reg;
   logic [CKS_W-1:0] cks_reg;
   logic [7:0] low_width_compare_reg;
   logic [7:0] high_width_compare_reg;
   logic [7:0] high_latch_reg;
   logic high_pending_reg;
   logic remote_output_enable_reg;
   logic gate_buffer_bit_reg;
   logic gate_active_bit_reg;
   logic pacer_count_enable_reg;
   logic [PACER_CKS_W-1:0] pacer_cks_reg;
   logic [7:0] pacer_cmp_reg;
   logic [7:0] pacer_counter_reg;
   logic [7:0] carrier_timer_reg;
   logic use_high_reg;
   logic carrier_clk_reg;
   logic carrier_prev_reg;
   logic first_tick_reg;
   logic pacer_irq_reg;
   logic pacer_pend_reg;
   logic sync_pulse_reg;
   logic [1:0] gate_cnt_reg;
   logic out_reg;
   logic irq_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic tick;
   logic pacer_tick;
   logic match;
   logic [7:0] cmp_sel;
   logic gate_load;

   assign wr_en = i_psel && i_penable && i_pwrite && !pready_reg;
   assign rd_en = i_psel && i_penable && !i_pwrite && !pready_reg;
   assign addr_ok = (i_paddr == MODE_OFFS) || (i_paddr == LOW_CMP_OFFS) ||
      (i_paddr == HIGH_CMP_OFFS) || (i_paddr == CARRIER_CTRL_OFFS) ||
      (i_paddr == PACER_CTRL_OFFS) || (i_paddr == PACER_CMP_OFFS) ||
      (i_paddr == STATUS_OFFS);
   assign cmp_sel = use_high_reg ? high_width_compare_reg : low_width_compare_reg;
   assign match = tick && !first_tick_reg && (carrier_timer_reg == cmp_sel);
   assign gate_load = tick && (gate_cnt_reg == 2'(GATE_DELAY - 1));

   clock_divider u_carrier_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sel(cks_reg),
      .i_run(carrier_timer_enable_reg),
      .o_tick(tick)
   );

   clock_divider u_pacer_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sel(pacer_cks_reg),
      .i_run(pacer_count_enable_reg),
      .o_tick(pacer_tick)
   );

   // ---------------------------------------------
   // APB slave, one wait state
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= i_psel && i_penable && !pready_reg;
         pslverr_reg <= i_psel && i_penable && !pready_reg && !addr_ok;
         if (rd_en) begin
            case (i_paddr)
               MODE_OFFS: prdata_reg <= 32'({carrier_timer_enable_reg, cks_reg, 4'h0});
               LOW_CMP_OFFS: prdata_reg <= 32'(low_width_compare_reg);
               HIGH_CMP_OFFS: prdata_reg <= 32'(high_width_compare_reg);
               CARRIER_CTRL_OFFS: prdata_reg <= 32'({remote_output_enable_reg,
                  gate_active_bit_reg, gate_buffer_bit_reg});
               PACER_CTRL_OFFS: prdata_reg <= 32'({pacer_count_enable_reg, 4'h0,
                  pacer_cks_reg});
               PACER_CMP_OFFS: prdata_reg <= 32'(pacer_cmp_reg);
               STATUS_OFFS: prdata_reg <= 32'({pacer_counter_reg, carrier_timer_reg});
               default: prdata_reg <= '0;
            endcase
         end else begin
            prdata_reg <= '0;
         end
      end
   end

   // ---------------------------------------------
   // Configuration writes
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         carrier_timer_enable_reg <= 1'b0;
         cks_reg <= '0;
         low_width_compare_reg <= CMP_RESET;
         remote_output_enable_reg <= 1'b0;
         gate_buffer_bit_reg <= 1'b0;
         pacer_count_enable_reg <= 1'b0;
         pacer_cks_reg <= '0;
         pacer_cmp_reg <= PACER_CMP_RESET;
      end else if (wr_en) begin
         case (i_paddr)
            MODE_OFFS: begin
               carrier_timer_enable_reg <= i_pwdata[MODE_EN_BIT];
               cks_reg <= i_pwdata[CKS_LSB +: CKS_W];
            end
            LOW_CMP_OFFS: low_width_compare_reg <= i_pwdata[7:0];
            CARRIER_CTRL_OFFS: begin
               remote_output_enable_reg <= i_pwdata[REMOTE_EN_BIT];
               gate_buffer_bit_reg <= i_pwdata[GATE_BUF_BIT];
            end
            PACER_CTRL_OFFS: begin
               pacer_count_enable_reg <= i_pwdata[PACER_EN_BIT];
               pacer_cks_reg <= i_pwdata[PACER_CKS_LSB +: PACER_CKS_W];
            end
            PACER_CMP_OFFS: pacer_cmp_reg <= i_pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------
   // High-width compare with latch
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         high_width_compare_reg <= CMP_RESET;
         high_latch_reg <= CMP_RESET;
         high_pending_reg <= 1'b0;
      end else begin
         if (wr_en && i_paddr == HIGH_CMP_OFFS) begin
            high_latch_reg <= i_pwdata[7:0];
            if (!carrier_timer_enable_reg) begin
               high_width_compare_reg <= i_pwdata[7:0];
               high_pending_reg <= 1'b0;
            end else begin
               high_pending_reg <= 1'b1;
            end
         end else if (match && use_high_reg && high_pending_reg) begin
            high_width_compare_reg <= high_latch_reg;
            high_pending_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Carrier counter and clock
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst || !carrier_timer_enable_reg) begin
         carrier_timer_reg <= CNT_CLEAR;
         use_high_reg <= 1'b0;
         carrier_clk_reg <= 1'b0;
         first_tick_reg <= 1'b1;
      end else if (tick) begin
         first_tick_reg <= 1'b0;
         if (first_tick_reg) begin
            carrier_timer_reg <= CNT_CLEAR;
         end else if (match) begin
            carrier_timer_reg <= CNT_CLEAR;
            use_high_reg <= !use_high_reg;
            carrier_clk_reg <= !carrier_clk_reg;
         end else begin
            carrier_timer_reg <= carrier_timer_reg + 8'h01;
         end
      end
   end

   // ---------------------------------------------
   // Match interrupt, one count clock wide
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst || !carrier_timer_enable_reg) begin
         irq_reg <= 1'b0;
      end else if (tick) begin
         irq_reg <= match;
      end
   end

   // ---------------------------------------------
   // Pacer counter
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst || !pacer_count_enable_reg) begin
         pacer_counter_reg <= CNT_CLEAR;
         pacer_irq_reg <= 1'b0;
      end else begin
         pacer_irq_reg <= 1'b0;
         if (pacer_tick) begin
            if (pacer_counter_reg == pacer_cmp_reg) begin
               pacer_counter_reg <= CNT_CLEAR;
               pacer_irq_reg <= 1'b1;
            end else begin
               pacer_counter_reg <= pacer_counter_reg + 8'h01;
            end
         end
      end
   end

   // ---------------------------------------------
   // Sync to count clock and gate transfer
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pacer_pend_reg <= 1'b0;
         sync_pulse_reg <= 1'b0;
         gate_cnt_reg <= '0;
         gate_active_bit_reg <= 1'b0;
      end else begin
         if (pacer_irq_reg) begin
            pacer_pend_reg <= 1'b1;
         end else if (tick) begin
            pacer_pend_reg <= 1'b0;
         end
         if (tick) begin
            sync_pulse_reg <= pacer_pend_reg || pacer_irq_reg;
            if (sync_pulse_reg && gate_cnt_reg == 2'h0) begin
               gate_cnt_reg <= 2'h1;
            end else if (gate_load) begin
               gate_cnt_reg <= 2'h0;
            end
         end
         if (gate_load) begin
            gate_active_bit_reg <= gate_buffer_bit_reg;
         end
      end
   end

   // ---------------------------------------------
   // Output selection
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         carrier_prev_reg <= 1'b0;
      end else begin
         carrier_prev_reg <= carrier_clk_reg;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         out_reg <= 1'b0;
      end else if (!remote_output_enable_reg) begin
         out_reg <= gate_buffer_bit_reg;
      end else if (!gate_buffer_bit_reg && !gate_active_bit_reg && !out_reg) begin
         out_reg <= 1'b0;
      end else if (out_reg) begin
         out_reg <= carrier_clk_reg;
      end else begin
         out_reg <= gate_active_bit_reg && carrier_clk_reg && !carrier_prev_reg;
      end
   end

   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_carrier_out_pin = out_reg;
   assign o_carrier_match_irq = irq_reg;
   assign o_pacer_irq = pacer_irq_reg;

   // ---------------------------------------------
   // Assertion sequences
   // ---------------------------------------------
   sequence s_low_match;
      match && !use_high_reg;
   endsequence
   sequence s_high_armed;
      use_high_reg && carrier_clk_reg && carrier_timer_reg == CNT_CLEAR;
   endsequence
   sequence s_high_match;
      match && use_high_reg;
   endsequence
   sequence s_low_armed;
      !use_high_reg && !carrier_clk_reg && carrier_timer_reg == CNT_CLEAR;
   endsequence

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_match_irq: assert property (@(posedge i_clk) disable iff (i_rst)
      (match && carrier_timer_enable_reg) |=> irq_reg)
      else $error("match irq missing");
   a_match_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (match && carrier_timer_enable_reg) |=> carrier_timer_reg == CNT_CLEAR)
      else $error("counter not cleared");
   a_match_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
      (match && carrier_timer_enable_reg) |=> carrier_clk_reg != $past(carrier_clk_reg))
      else $error("carrier not inverted");
   a_enable_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(carrier_timer_enable_reg) |-> !carrier_clk_reg)
      else $error("carrier active at enable");
   a_stop_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(carrier_timer_enable_reg) |=> (carrier_timer_reg == CNT_CLEAR && !irq_reg))
      else $error("counter not stopped");
   a_gate_copy: assert property (@(posedge i_clk) disable iff (i_rst)
      gate_load |=> gate_active_bit_reg == $past(gate_buffer_bit_reg))
      else $error("gate copy wrong");
   a_no_truncate: assert property (@(posedge i_clk) disable iff (i_rst)
      (remote_output_enable_reg && out_reg && carrier_clk_reg) |=> out_reg)
      else $error("high pulse truncated");
   a_gate_off_low: assert property (@(posedge i_clk) disable iff (i_rst)
      (remote_output_enable_reg && !gate_active_bit_reg && !out_reg) |=> !out_reg)
      else $error("output leaked while gated");
   a_start_rise: assert property (@(posedge i_clk) disable iff (i_rst)
      ($rose(out_reg) && $past(remote_output_enable_reg)) |->
      ($past(carrier_clk_reg) && !$past(carrier_clk_reg, 2)))
      else $error("carrier started mid phase");
   a_high_apply: assert property (@(posedge i_clk) disable iff (i_rst)
      (match && use_high_reg && high_pending_reg && !(wr_en && i_paddr == HIGH_CMP_OFFS)) |=>
      high_width_compare_reg == $past(high_latch_reg))
      else $error("latched high compare not applied");
   a_low_to_high: assert property (@(posedge i_clk) disable iff (i_rst)
      s_low_match |=> s_high_armed)
      else $error("low match did not switch to high");
   a_high_to_low: assert property (@(posedge i_clk) disable iff (i_rst)
      s_high_match |=> s_low_armed)
      else $error("high match did not switch to low");
endmodule
`default_nettype wire

// ===== hdl/ir_carrier_pkg.sv
package ir_carrier_pkg;
   localparam logic [11:0] MODE_OFFS = 12'h000;
   localparam logic [11:0] LOW_CMP_OFFS = 12'h004;
   localparam logic [11:0] HIGH_CMP_OFFS = 12'h008;
   localparam logic [11:0] CARRIER_CTRL_OFFS = 12'h00c;
   localparam logic [11:0] PACER_CTRL_OFFS = 12'h010;
   localparam logic [11:0] PACER_CMP_OFFS = 12'h014;
   localparam logic [11:0] STATUS_OFFS = 12'h018;
   // Mode register fields
   localparam int MODE_EN_BIT = 7;
   localparam int CKS_LSB = 4;
   localparam int CKS_W = 3;
   // Carrier control fields
   localparam int REMOTE_EN_BIT = 2;
   localparam int GATE_ACT_BIT = 1;
   localparam int GATE_BUF_BIT = 0;
   // Pacer control fields
   localparam int PACER_EN_BIT = 7;
   localparam int PACER_CKS_LSB = 0;
   localparam int PACER_CKS_W = 3;
   localparam logic [7:0] CMP_RESET = 8'h01;
   localparam logic [7:0] CNT_CLEAR = 8'h00;
   localparam logic [7:0] PACER_CMP_RESET = 8'hff;
   localparam int PRESCALE_W = 8;
   localparam int GATE_DELAY = 2;
endpackage

// ===== hdl/clock_divider.sv
`timescale 1ns/1ns
`default_nettype none
module clock_divider
   import ir_carrier_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [CKS_W-1:0] i_sel,
   input wire logic i_run,
   output logic o_tick
);
   logic [PRESCALE_W-1:0] prescale_reg;
   logic [PRESCALE_W:0] wide_sum;
   assign wide_sum = {1'b0, prescale_reg} + 9'h001;

   // ---------------------------------------------
   // Free prescaler, tick every 2^sel clocks
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run) begin
         prescale_reg <= '0;
      end else begin
         prescale_reg <= wide_sum[PRESCALE_W-1:0];
      end
   end

   always_comb begin
      if (!i_run) begin
         o_tick = 1'b0;
      end else if (i_sel == 3'h0) begin
         o_tick = 1'b1;
      end else begin
         o_tick = (prescale_reg & ((8'h01 << i_sel) - 8'h01)) == ((8'h01 << i_sel) - 8'h01);
      end
   end
endmodule
`default_nettype wire

// ===== test/ir_led_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------
// Monitor stage: measures pin level run widths
// ------------------------------------------
module ir_led_monitor (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   output logic [15:0] o_high_len,
   output logic [15:0] o_low_len
);
   logic pin_reg;
   logic [15:0] run_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_reg <= 1'b0;
         run_reg <= 16'h0000;
         o_high_len <= 16'h0000;
         o_low_len <= 16'h0000;
      end else if (i_pin !== pin_reg) begin
         if (pin_reg) begin
            o_high_len <= run_reg;
         end else begin
            o_low_len <= run_reg;
         end
         pin_reg <= i_pin;
         run_reg <= 16'h0001;
      end else begin
         run_reg <= run_reg + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ===== test/ir_carrier_generator_test.sv
`timescale 1ns/1ns
`default_nettype none
module ir_carrier_generator_test;
   import ir_carrier_pkg::*;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_t;
   logic clk = 1'b0;
   logic rst, psel, penable, pwrite, pready, pslverr, pin, mirq, pirq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] high_len, low_len;
   int fail_count = 0;
   int check_count = 0;
   int c, p;
   row_t rows[8] = '{'{0, MODE_OFFS, 0, 0, 0}, '{0, LOW_CMP_OFFS, 0, 1, 0},
      '{0, HIGH_CMP_OFFS, 0, 1, 0}, '{0, CARRIER_CTRL_OFFS, 0, 0, 0},
      '{0, PACER_CMP_OFFS, 0, 32'hff, 0}, '{0, STATUS_OFFS, 0, 0, 0},
      '{1, CARRIER_CTRL_OFFS, 3, 1, 0}, '{1, 12'h01c, 5, 0, 1}};
   always #25 clk = ~clk;
   ir_carrier_generator ir_carrier_generator_inst (.i_clk(clk), .i_rst(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_carrier_out_pin(pin),
      .o_carrier_match_irq(mirq), .o_pacer_irq(pirq));
   ir_led_monitor ir_led_monitor_inst (.i_clk(clk), .i_rst(rst), .i_pin(pin),
      .o_high_len(high_len), .o_low_len(low_len));
   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task end_sim;
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task check(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 0, rd, er);
      check(n, e, rd);
   endtask
   task count(input int n, output int cm, output int cp);
      cm = 0;
      cp = 0;
      repeat (n) begin
         @(posedge clk);
         cm += (mirq === 1'b1);
         cp += (pirq === 1'b1);
      end
   endtask
   // ------------------------------------------
   // Watchdog
   // ------------------------------------------
   initial begin
      #(50 * 20000);
      fail_count++;
      end_sim;
   end
   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      logic [31:0] rd;
      logic er;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("pin", 0, pin);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].a, rows[i].d);
         end
         apb(1'b0, rows[i].a, 0, rd, er);
         check("rdata", rows[i].e, rd);
         check("slverr", rows[i].er, er);
      end
      for (int k = 0; k < 3; k++) begin
         wr(CARRIER_CTRL_OFFS, (k == 0) ? 1 : (k == 1) ? 0 : 4);
         repeat (4) @(posedge clk);
         check("pin", k == 0, pin);
      end
      wr(LOW_CMP_OFFS, 32'h3);
      wr(HIGH_CMP_OFFS, 32'h5);
      wr(CARRIER_CTRL_OFFS, 32'h5);
      wr(PACER_CMP_OFFS, 32'h4);
      count(200, c, p);
      check("pacer_irq", 0, p);
      wr(PACER_CTRL_OFFS, 32'h83);
      wr(MODE_OFFS, 32'h80);
      repeat (600) @(posedge clk);
      count(100, c, p);
      check("match_irq", 20, c);
      check("pacer_irq", 1, p > 0);
      check("high_len", 6, high_len);
      check("low_len", 4, low_len);
      rdchk("ctrl", CARRIER_CTRL_OFFS, 7);
      wr(HIGH_CMP_OFFS, 32'h2);
      repeat (300) @(posedge clk);
      check("high_len", 3, high_len);
      check("low_len", 4, low_len);
      wr(CARRIER_CTRL_OFFS, 32'h4);
      repeat (300) @(posedge clk);
      check("pin", 0, pin);
      check("high_len", 3, high_len);
      rdchk("ctrl", CARRIER_CTRL_OFFS, 4);
      wr(MODE_OFFS, 32'h0);
      count(100, c, p);
      check("match_irq", 0, c);
      wr(HIGH_CMP_OFFS, 32'h1);
      wr(CARRIER_CTRL_OFFS, 32'h5);
      wr(MODE_OFFS, 32'h80);
      repeat (600) @(posedge clk);
      check("high_len", 2, high_len);
      check("low_len", 4, low_len);
      wr(MODE_OFFS, 32'h0);
      wr(PACER_CTRL_OFFS, 32'h84);
      wr(HIGH_CMP_OFFS, 32'h1);
      wr(MODE_OFFS, 32'h90);
      repeat (600) @(posedge clk);
      check("high_len", 4, high_len);
      check("low_len", 8, low_len);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("pin", 0, pin);
      check("match_irq", 0, mirq);
      rdchk("mode", MODE_OFFS, 0);
      end_sim;
   end
endmodule
`default_nettype wire
